// File: rtl/ddio_group.sv
// one 24-line group: sync, direction, output latch, change and edge detect
module ddio_group
  import ddio_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // pins
  input  wire logic [23:0] i_pin,
  // host side
  input  wire logic        i_wr,
  input  wire logic [1:0]  i_sel,
  input  wire logic [7:0]  i_wdata,
  // state out
  output logic      [23:0] o_level,
  output logic      [23:0] o_drive,
  output logic      [23:0] o_oe,
  output logic      [7:0]  o_dir_rd,
  output logic      [2:0]  o_change,
  output logic             o_bit3_rise
);
  logic [23:0] s1_q, s2_q, s3_q;
  logic [23:0] drv_q;
  logic [2:0]  written_q;
  logic [4:0]  dir_q;
  logic [23:0] in_mask;

  // ==========================================================
  // three-stage sync; a change or edge counts while stages 2 and 3 differ
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // direction bits; all inputs after reset
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dir_q <= DDIO_DIR_RESET;
    end else if (i_wr && i_sel == 2'd3) begin
      dir_q <= {i_wdata[DDIO_DIR_FIRST], i_wdata[DDIO_DIR_THIRD_HI], 1'b0,
                i_wdata[DDIO_DIR_SECOND], i_wdata[DDIO_DIR_THIRD_LO]};
    end
  end

  // per-line input flag, third port split in nybbles
  assign in_mask = {{4{dir_q[3]}}, {4{dir_q[0]}}, {8{dir_q[1]}}, {8{dir_q[4]}}};

  // ==========================================================
  // output latch; input lines of unwritten ports track the pins so the switch is glitch-free
  for (genvar p = 0; p < 3; p++) begin : g_port
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        written_q[p]       <= 1'b0;
        drv_q[p*8 +: 8]    <= 8'h00;
      end else if (i_wr && i_sel == p[1:0]) begin
        written_q[p]       <= 1'b1;
        drv_q[p*8 +: 8]    <= i_wdata;
      end else if (!written_q[p]) begin
        drv_q[p*8 +: 8]    <= s3_q[p*8 +: 8] & in_mask[p*8 +: 8] |
                              drv_q[p*8 +: 8] & ~in_mask[p*8 +: 8];
      end
    end
    assign o_change[p] = |(s2_q[p*8 +: 8] ^ s3_q[p*8 +: 8]);
  end

  assign o_drive     = drv_q;
  assign o_oe        = ~in_mask;
  assign o_level     = (s3_q & in_mask) | (drv_q & ~in_mask);
  assign o_dir_rd    = {3'b000, dir_q} & DDIO_DIR_RD_MASK;
  assign o_bit3_rise = s2_q[19] & ~s3_q[19];
endmodule : ddio_group

// File: rtl/ddio_pkg.sv
package ddio_pkg;
  // ==========================================================
  // register offsets within the sixteen-byte window
  localparam logic [3:0] DDIO_OFF_G0_FIRST  = 4'h0;
  localparam logic [3:0] DDIO_OFF_G0_SECOND = 4'h1;
  localparam logic [3:0] DDIO_OFF_G0_THIRD  = 4'h2;
  localparam logic [3:0] DDIO_OFF_G0_DIR    = 4'h3;
  localparam logic [3:0] DDIO_OFF_G1_FIRST  = 4'h4;
  localparam logic [3:0] DDIO_OFF_G1_SECOND = 4'h5;
  localparam logic [3:0] DDIO_OFF_G1_THIRD  = 4'h6;
  localparam logic [3:0] DDIO_OFF_G1_DIR    = 4'h7;
  localparam logic [3:0] DDIO_OFF_IRQ_EN    = 4'hb;
  localparam logic [3:0] DDIO_OFF_IRQ_STAT  = 4'hf;

  // ==========================================================
  // direction register field positions (1 = input)
  localparam int DDIO_DIR_THIRD_LO = 0;
  localparam int DDIO_DIR_SECOND   = 1;
  localparam int DDIO_DIR_THIRD_HI = 3;
  localparam int DDIO_DIR_FIRST    = 4;
  localparam int DDIO_DIR_SET      = 7;
  localparam logic [7:0] DDIO_DIR_RD_MASK  = 8'h1b;
  localparam logic [4:0] DDIO_DIR_RESET    = 5'h1f;

  // ==========================================================
  // interrupt enable fields and reset values
  localparam int DDIO_IEN_HW0 = 6;
  localparam int DDIO_IEN_HW1 = 7;
  localparam logic [5:0] DDIO_COS_DIS_RESET = 6'h3f;
  localparam logic [5:0] DDIO_STAT_RESET    = 6'h00;
endpackage : ddio_pkg

// File: rtl/ddio_top.sv
module ddio_top
  import ddio_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // host register port, offset within the window
  input  wire logic [3:0]  i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  // hardware enables for the bit-3 edge interrupt, one per group
  input  wire logic        i_group0_edge_irq_hw_enable,
  input  wire logic        i_group1_edge_irq_hw_enable,
  // field lines, group 1 in the upper half
  input  wire logic [47:0] i_pin,
  output logic      [47:0] o_pin,
  output logic      [47:0] o_pin_oe,
  // interrupt request
  output logic             o_irq
);
  logic [47:0] level, drive, oe;
  logic [7:0]  dir_rd [2];
  logic [5:0]  change;
  logic [1:0]  rise;
  logic [1:0]  hw_s1_q, hw_s2_q, hw_s3_q, hw_en;
  logic [5:0]  cos_dis_q;
  logic [5:0]  stat_q;
  logic [1:0]  armed_q;
  logic        edge_pend_q;
  logic        stat_clr, ien_acc;
  logic [7:0]  rdata_d;

  assign stat_clr = i_wr && i_addr == DDIO_OFF_IRQ_STAT;
  assign ien_acc  = (i_rd || i_wr) && i_addr == DDIO_OFF_IRQ_EN;

  // ==========================================================
  // two groups from one module
  for (genvar g = 0; g < 2; g++) begin : g_grp
    ddio_group u_grp (
      .i_clk       (i_clk),
      .i_rstn      (i_rstn),
      .i_pin       (i_pin[g*24 +: 24]),
      .i_wr        (i_wr && i_addr[3] == 1'b0 && i_addr[2] == g[0]),
      .i_sel       (i_addr[1:0]),
      .i_wdata     (i_wdata),
      .o_level     (level[g*24 +: 24]),
      .o_drive     (drive[g*24 +: 24]),
      .o_oe        (oe[g*24 +: 24]),
      .o_dir_rd    (dir_rd[g]),
      .o_change    (change[g*3 +: 3]),
      .o_bit3_rise (rise[g])
    );
  end

  // ==========================================================
  // pin outputs registered
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin    <= '0;
      o_pin_oe <= '0;
    end else begin
      o_pin    <= drive;
      o_pin_oe <= oe;
    end
  end

  // ==========================================================
  // jumper enables come from outside, so synchronise them too
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hw_s1_q <= 2'b00;
      hw_s2_q <= 2'b00;
      hw_s3_q <= 2'b00;
      hw_en   <= 2'b00;
    end else begin
      hw_s1_q <= {i_group1_edge_irq_hw_enable, i_group0_edge_irq_hw_enable};
      hw_s2_q <= hw_s1_q;
      hw_s3_q <= hw_s2_q;
      for (int k = 0; k < 2; k++) begin
        if (hw_s2_q[k] == hw_s3_q[k]) begin
          hw_en[k] <= hw_s3_q[k];
        end
      end
    end
  end

  // ==========================================================
  // change-detect disables: written 1 disables, reset disables all
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cos_dis_q <= DDIO_COS_DIS_RESET;
    end else if (i_wr && i_addr == DDIO_OFF_IRQ_EN) begin
      cos_dis_q <= i_wdata[5:0];
    end
  end

  // ==========================================================
  // edge arming; losing the jumper disarms so replug needs a new access
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      armed_q <= 2'b00;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (!hw_en[k]) begin
          armed_q[k] <= 1'b0;
        end else if (ien_acc) begin
          armed_q[k] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // sticky change flags; a new event beats a same-cycle clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stat_q <= DDIO_STAT_RESET;
    end else begin
      stat_q <= (stat_clr ? 6'h00 : stat_q) | (change & ~cos_dis_q);
    end
  end

  // edge events have no status bit, so hold a pending flag for them
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      edge_pend_q <= 1'b0;
    end else begin
      edge_pend_q <= (edge_pend_q & ~stat_clr) | |(rise & armed_q);
    end
  end

  // ==========================================================
  // request held while anything is pending
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= ((stat_clr ? 6'h00 : stat_q) != 6'h00) | (change & ~cos_dis_q) != 6'h00
               | (edge_pend_q & ~stat_clr) | |(rise & armed_q);
    end
  end

  // ==========================================================
  // read mux; unused offsets return zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (i_addr)
      DDIO_OFF_G0_FIRST:  rdata_d = level[7:0];
      DDIO_OFF_G0_SECOND: rdata_d = level[15:8];
      DDIO_OFF_G0_THIRD:  rdata_d = level[23:16];
      DDIO_OFF_G0_DIR:    rdata_d = dir_rd[0];
      DDIO_OFF_G1_FIRST:  rdata_d = level[31:24];
      DDIO_OFF_G1_SECOND: rdata_d = level[39:32];
      DDIO_OFF_G1_THIRD:  rdata_d = level[47:40];
      DDIO_OFF_G1_DIR:    rdata_d = dir_rd[1];
      DDIO_OFF_IRQ_EN:    rdata_d = {hw_en[1], hw_en[0], ~cos_dis_q};
      DDIO_OFF_IRQ_STAT:  rdata_d = {2'b00, stat_q};
      default:            rdata_d = 8'h00;
    endcase
  end

  // read data registered: valid the cycle after i_rd
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end
  end
endmodule : ddio_top

// File: verification/ddio_checker.sv
module ddio_checker (
  // clock, reset and host port
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic [3:0]  i_addr,
  input wire logic        i_rd,
  input wire logic        i_wr,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  o_rdata,
  // enables, lines and request
  input wire logic        i_group0_edge_irq_hw_enable,
  input wire logic        i_group1_edge_irq_hw_enable,
  input wire logic [47:0] i_pin,
  input wire logic [47:0] o_pin_oe,
  input wire logic        o_irq
);
  // ====================
  // input quiet time
  logic [49:0] cur;
  logic [49:0] prev_q;
  logic [3:0]  quiet_q;
  assign cur = {i_group1_edge_irq_hw_enable, i_group0_edge_irq_hw_enable, i_pin};
  // saturating count, so guards never see a change still in the synchronisers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_q  <= '0;
      quiet_q <= '0;
    end else begin
      prev_q  <= cur;
      quiet_q <= (cur != prev_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
    end
  end
  function automatic logic [23:0] oe_of(input logic [7:0] d);
    return {{4{~d[3]}}, {4{~d[0]}}, {8{~d[1]}}, {8{~d[4]}}};
  endfunction : oe_of
  // ====================
  // properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  AST_RST_IDLE: assert property ($rose(i_rstn) |-> o_pin_oe == '0 && !o_irq)
    else $error("lines or request active after reset");
  AST_UNUSED_RD: assert property (i_rd && i_addr inside {4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he}
    |=> o_rdata == 8'h00) else $error("unused offset read not zero");
  AST_DIR_RD: assert property (i_rd && !i_addr[3] && i_addr[1:0] == 2'h3
    |=> (o_rdata & 8'he4) == 8'h00) else $error("direction spare bits not zero");
  AST_STAT_RD: assert property (i_rd && i_addr == 4'hf |=> o_rdata[7:6] == 2'h0)
    else $error("status top bits not zero");
  AST_IEN_HW: assert property (i_rd && i_addr == 4'hb && quiet_q > 4'h8
    |=> o_rdata[7:6] == {i_group1_edge_irq_hw_enable, i_group0_edge_irq_hw_enable})
    else $error("enable top bits differ from jumpers");
  AST_OE_WRITE: assert property ((i_wr && i_addr == 4'h3) ##1 !(i_wr && i_addr == 4'h3)
    |=> o_pin_oe[23:0] == oe_of($past(i_wdata, 2))) else $error("group 0 enables wrong");
  AST_IRQ_HOLD: assert property (o_irq && !(i_wr && i_addr == 4'hf) |=> o_irq)
    else $error("request dropped without status write");
  AST_STAT_CLR: assert property (i_wr && i_addr == 4'hf && quiet_q > 4'h8 |=> !o_irq)
    else $error("status write left request up");
endmodule : ddio_checker

bind ddio_top ddio_checker u_chk (.i_clk, .i_rstn, .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata,
  .i_group0_edge_irq_hw_enable, .i_group1_edge_irq_hw_enable, .i_pin, .o_pin_oe, .o_irq);

// File: verification/ddio_top_tb.sv
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module ddio_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ddio_pkg::*;
  logic        i_clk, i_rstn, i_rd, i_wr, hw0, hw1, o_irq;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata, d;
  logic [47:0] i_pin, o_pin, o_pin_oe, src;
  logic [3:0]  spare [6] = '{4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he};
  int          seed, mismatches, cmp_count;
  ddio_top uut (.i_clk, .i_rstn, .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata,
    .i_group0_edge_irq_hw_enable(hw0), .i_group1_edge_irq_hw_enable(hw1),
    .i_pin, .o_pin, .o_pin_oe, .o_irq);
  ddio_wiring u_field (.i_drv(o_pin), .i_oe(o_pin_oe), .i_src(src), .i_src_en({48{1'b1}}),
    .o_line(i_pin));
  // ====================
  // clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [23:0] exp_oe(input logic [7:0] v);
    return {{4{~v[3]}}, {4{~v[0]}}, {8{~v[1]}}, {8{~v[4]}}};
  endfunction : exp_oe
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // read data holds until the next read, so one edge of slack is safe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    tick(1);
    `CHK("rdata", e, o_rdata)
  endtask : rd
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // bounded wait for the request level
  task automatic wait_irq(input logic e);
    for (int n = 0; n < 20 && o_irq !== e; n++) tick(1);
    `CHK("irq", e, o_irq)
    if (o_irq !== e) end_sim();
  endtask : wait_irq
  // ====================
  // main sequence
  initial begin
    {i_rstn, i_rd, i_wr, hw0, hw1, i_addr, i_wdata, src} = '0;
    seed = 86;
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    tick(1);
    `CHK("oe", 48'h0, o_pin_oe)
    `CHK("irq", 1'b0, o_irq)
    rd(4'h3, 8'h1b);
    rd(4'hb, 8'h00);
    src <= 48'({$random(seed), $random(seed)});
    tick(6);
    for (int k = 0; k < 6; k++) rd(4'(k + k / 3), src[8 * k +: 8]);
    wr(4'h3, 8'h80);
    tick(2);
    `CHK("pin", src[23:0], o_pin[23:0])
    d = 8'($random(seed));
    wr(4'h4, d);
    tick(2);
    `CHK("oe", 24'h0, o_pin_oe[47:24])
    wr(4'h7, 8'h8b);
    tick(2);
    `CHK("pin", d, o_pin[31:24])
    `CHK("oe", exp_oe(8'h0b), o_pin_oe[47:24])
    rd(4'h4, d);
    for (int k = 0; k < 8; k++) begin
      d = (k == 0) ? 8'hff : 8'($random(seed));
      wr(4'h3, d | 8'h80);
      tick(2);
      `CHK("oe", exp_oe(d), o_pin_oe[23:0])
      rd(4'h3, d & 8'h1b);
    end
    foreach (spare[k]) begin
      wr(spare[k], 8'hff);
      rd(spare[k], 8'h00);
    end
    src[19] <= 1'b0;
    wr(4'h3, 8'h9b);
    tick(8);
    wr(4'hb, 8'h3e);
    rd(4'hb, 8'h01);
    src[0] <= ~src[0];
    wait_irq(1'b1);
    src[8] <= ~src[8];
    tick(8);
    rd(4'hf, 8'h01);
    wr(4'hf, 8'h5a);
    tick(1);
    `CHK("irq", 1'b0, o_irq)
    wr(4'hb, 8'h3f);
    hw0 <= 1'b1;
    hw1 <= 1'b1;
    tick(10);
    src[19] <= 1'b1;
    tick(8);
    `CHK("irq", 1'b0, o_irq)
    src[19] <= 1'b0;
    tick(8);
    rd(4'hb, 8'hc0);
    src[19] <= 1'b1;
    wait_irq(1'b1);
    rd(4'hf, 8'h00);
    wr(4'hf, 8'h00);
    src[19] <= 1'b0;
    tick(10);
    `CHK("irq", 1'b0, o_irq)
    end_sim();
  end
endmodule : ddio_top_tb

// File: verification/ddio_wiring.sv
module ddio_wiring #(
  parameter logic PULL = 1'b1
) (
  // design side
  input  wire logic [47:0] i_drv,
  input  wire logic [47:0] i_oe,
  // field sources
  input  wire logic [47:0] i_src,
  input  wire logic [47:0] i_src_en,
  // resolved lines
  output logic      [47:0] o_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // field releases where the card drives; idle lines sit at the resistor level
  assign o_line = (i_oe & i_drv) | (~i_oe & i_src_en & i_src) | (~i_oe & ~i_src_en & {48{PULL}});
endmodule : ddio_wiring
